// ---- rtl/psbs_pkg.sv ----
package psbs_pkg;
  // path widths
  localparam int AD_W   = 64;  // full address/data path
  localparam int AD_W32 = 32;  // lanes used in 32-bit mode
  localparam int CK_W   = 8;   // parity lanes
  localparam int CK_W32 = 4;   // parity lanes in 32-bit mode
  localparam int CMD_W  = 9;   // command / data identifier
  localparam int TAG_W  = 3;   // request tag
  // strap levels
  localparam logic WIDTH_64      = 1'b1;  // width_select high: 64 bits
  localparam logic UNORDERED_LVL = 1'b0;  // return select low: out-of-order
  // reset values of active-low outputs
  localparam logic DEASSERT_N = 1'b1;  // idle level of every _n line
  // command field: bit 8 set marks a data identifier
  localparam int CMD_DATA_BIT = 8;
  // bus ownership states
  typedef enum logic [1:0] {
    PSBS_MASTER  = 2'b00,  // cpu owns the bus, idle
    PSBS_ISSUE   = 2'b01,  // cpu drives a request cycle
    PSBS_RELEASE = 2'b11,  // handing the bus over
    PSBS_SLAVE   = 2'b10   // agent owns the bus
  } psbs_state_t;
endpackage

// ---- rtl/psbs_lane_mask.sv ----
// masks the path and its parity down to the lanes in use for the chosen width
module psbs_lane_mask
  import psbs_pkg::*;
(
  input  wire logic            wide,      // high: 64-bit mode
  input  wire logic [AD_W-1:0] ad_in,     // raw data
  output      logic [AD_W-1:0] ad_out,    // masked data
  output      logic [CK_W-1:0] par_out    // even parity per byte lane, masked
);
  // one parity bit per byte lane; upper lanes forced low in 32-bit mode
  // masking lives here so data and parity can never disagree on width
  genvar g;
  generate
    for (g = 0; g < CK_W; g++)
    begin : g_lane
      if (g < CK_W32)
      begin : g_lo
        assign ad_out[g*8 +: 8] = ad_in[g*8 +: 8];
        assign par_out[g]       = ^ad_in[g*8 +: 8];
      end
      else
      begin : g_hi
        assign ad_out[g*8 +: 8] = wide ? ad_in[g*8 +: 8] : 8'h00;
        assign par_out[g]       = ^ad_out[g*8 +: 8];
      end
    end
  endgenerate
endmodule

// ---- rtl/psbs_core.sv ----
// Functional notes
// - 64-bit path, lower half in 32-bit mode
// - byte parity, data cycles, four lanes narrow
// - nine-bit command/data identifier path both ways
// - cpu tag valid with its valid strobe in out-of-order mode
// - cpu strobe marks exactly its valid cycles
// - release pulse hands bus to agent
// - pending output while request waits
// - hash-marked lines are active low
module psbs_core
  import psbs_pkg::*;
(
  input  wire logic             sys_clk,                 // system clock
  input  wire logic             sys_rst,                 // sync reset, high
  // configuration straps
  input  wire logic             width_select,            // 1: 64-bit bus
  input  wire logic             unordered_return_sel_n,  // 0: out-of-order
  // address/data path, split three-state
  input  wire logic [AD_W-1:0]  addr_data_bus_i,         // pin level
  output      logic [AD_W-1:0]  addr_data_bus_o,         // driven value
  output      logic             addr_data_bus_oe,        // high while driving
  input  wire logic [CK_W-1:0]  parity_check_bus_i,      // pin level
  output      logic [CK_W-1:0]  parity_check_bus_o,      // driven parity
  output      logic             parity_check_bus_oe,     // high while driving
  input  wire logic [CMD_W-1:0] command_id_bus_i,        // pin level
  output      logic [CMD_W-1:0] command_id_bus_o,        // driven id
  output      logic             command_id_bus_oe,       // high while driving
  input  wire logic [TAG_W-1:0] request_tag_bus_i,       // pin level
  output      logic [TAG_W-1:0] request_tag_bus_o,       // driven tag
  output      logic             request_tag_bus_oe,      // high while driving
  // handshake pins
  input  wire logic             agent_valid_n,           // agent strobe
  output      logic             cpu_valid_n,             // cpu strobe
  input  wire logic             read_accept_n,           // agent takes reads
  input  wire logic             write_accept_n,          // agent takes writes
  input  wire logic             agent_bus_request_n,     // agent wants bus
  output      logic             release_n,               // bus handed over
  output      logic             cpu_pending_n,           // request waiting
  // core-side request port
  input  wire logic             req_valid,               // new request
  input  wire logic             req_write,               // 1 write, 0 read
  input  wire logic [AD_W-1:0]  req_addr_data,           // request word
  input  wire logic [CMD_W-1:0] req_cmd,                 // request command
  input  wire logic [TAG_W-1:0] req_tag,                 // request tag
  output      logic             req_ready,               // request slot free
  // core-side receive port
  output      logic             rx_valid,                // agent word seen
  output      logic [AD_W-1:0]  rx_addr_data,            // masked word
  output      logic [CMD_W-1:0] rx_cmd,                  // received id
  output      logic [TAG_W-1:0] rx_tag,                  // received tag
  output      logic             rx_parity_err            // data parity bad
);

  psbs_state_t state_q;                // ownership state
  logic        wide_q;                 // latched width mode
  logic        unord_q;                // latched out-of-order mode
  logic        strap_done_q;           // straps taken after reset
  logic        hold_q;                 // request held in slot
  logic        hold_wr_q;              // held request is a write
  logic [AD_W-1:0]  hold_ad_q;         // held word
  logic [CMD_W-1:0] hold_cmd_q;        // held command
  logic [TAG_W-1:0] hold_tag_q;        // held tag
  logic [AD_W-1:0]  ad_mask;           // lane mask for width
  logic [CK_W-1:0]  tx_par;            // parity of outgoing word
  logic [CK_W-1:0]  rx_par;            // parity of incoming word
  logic        accept_ok;              // matching ready asserted
  logic        agent_req;              // agent asks for bus
  logic        issue;                  // request goes out this cycle

  assign ad_mask   = wide_q ? {AD_W{1'b1}} : {{AD_W32{1'b0}}, {AD_W32{1'b1}}};
  // active-low accept and bus-request inputs decoded once here; agent strobe decoded in the capture block
  assign accept_ok = hold_wr_q ? ~write_accept_n : ~read_accept_n;
  assign agent_req = ~agent_bus_request_n;
  // issue only while master and the agent can accept the kind
  assign issue     = hold_q && accept_ok && state_q == PSBS_MASTER
                     && !agent_req && strap_done_q;

  // parity generators share the lane masking
  psbs_lane_mask u_txpar (
    .wide    (wide_q),
    .ad_in   (hold_ad_q & ad_mask),
    .ad_out  (),
    .par_out (tx_par)
  );
  psbs_lane_mask u_rxpar (
    .wide    (wide_q),
    .ad_in   (addr_data_bus_i & ad_mask),
    .ad_out  (),
    .par_out (rx_par)
  );

  // straps caught at the first edge after reset release, then frozen
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      strap_done_q <= 1'b0;
      wide_q       <= 1'b0;
      unord_q      <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      strap_done_q <= 1'b1;
      wide_q       <= (width_select == WIDTH_64);
      unord_q      <= (unordered_return_sel_n == UNORDERED_LVL);
    end
  end

  // one-deep request slot; core may only load when empty
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      hold_q     <= 1'b0;
      hold_wr_q  <= 1'b0;
      hold_ad_q  <= '0;
      hold_cmd_q <= '0;
      hold_tag_q <= '0;
    end
    else if (issue)
    begin
      hold_q <= 1'b0;
    end
    else if (req_valid && !hold_q)
    begin
      hold_q     <= 1'b1;
      hold_wr_q  <= req_write;
      hold_ad_q  <= req_addr_data;
      hold_cmd_q <= req_cmd;
      hold_tag_q <= req_tag;
    end
  end

  // ownership: master, issue cycle, release, slave
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      state_q <= PSBS_MASTER;
    else
    begin
      case (state_q)
        PSBS_MASTER:
        begin
          if (issue)
            state_q <= PSBS_ISSUE;
          else if (agent_req && strap_done_q)
            state_q <= PSBS_RELEASE;
        end
        PSBS_ISSUE:
        begin
          state_q <= agent_req ? PSBS_RELEASE : PSBS_MASTER;
        end
        PSBS_RELEASE:
          state_q <= PSBS_SLAVE;
        PSBS_SLAVE:
        begin
          // bus returns once the agent drops its request
          if (!agent_req)
            state_q <= PSBS_MASTER;
        end
        default:
          state_q <= PSBS_MASTER;
      endcase
    end
  end

  // outgoing pins registered; strobe, data, id and tag move together
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cpu_valid_n         <= DEASSERT_N;
      addr_data_bus_o     <= '0;
      parity_check_bus_o  <= '0;
      command_id_bus_o    <= '0;
      request_tag_bus_o   <= '0;
    end
    else
    begin
      cpu_valid_n <= ~issue;
      if (issue)
      begin
        addr_data_bus_o    <= hold_ad_q & ad_mask;
        parity_check_bus_o <= hold_cmd_q[CMD_DATA_BIT] ? tx_par : '0;
        command_id_bus_o   <= hold_cmd_q;
        request_tag_bus_o  <= unord_q ? hold_tag_q : '0;
      end
    end
  end

  // drivers on only while the cpu owns the bus; off from release on
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      addr_data_bus_oe    <= 1'b0;
      parity_check_bus_oe <= 1'b0;
      command_id_bus_oe   <= 1'b0;
      request_tag_bus_oe  <= 1'b0;
    end
    else
    begin
      addr_data_bus_oe    <= issue;
      parity_check_bus_oe <= issue;
      command_id_bus_oe   <= issue;
      request_tag_bus_oe  <= issue && unord_q;
    end
  end

  // release strobe and pending flag
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      release_n     <= DEASSERT_N;
      cpu_pending_n <= DEASSERT_N;
      req_ready     <= 1'b0;
    end
    else
    begin
      release_n     <= ~(state_q != PSBS_RELEASE && (state_q == PSBS_MASTER
                       || state_q == PSBS_ISSUE) && !issue && agent_req
                       && strap_done_q);
      cpu_pending_n <= ~(hold_q && !issue);
      // slot free next cycle when empty and not loading, or emptying
      req_ready     <= strap_done_q && (issue || !(hold_q || req_valid));
    end
  end

  // capture agent cycles; ignored while the cpu drives the bus
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rx_valid      <= 1'b0;
      rx_addr_data  <= '0;
      rx_cmd        <= '0;
      rx_tag        <= '0;
      rx_parity_err <= 1'b0;
    end
    else
    begin
      rx_valid <= ~agent_valid_n && !addr_data_bus_oe;
      if (~agent_valid_n && !addr_data_bus_oe)
      begin
        rx_addr_data  <= addr_data_bus_i & ad_mask;
        rx_cmd        <= command_id_bus_i;
        rx_tag        <= unord_q ? request_tag_bus_i : '0;
        rx_parity_err <= command_id_bus_i[CMD_DATA_BIT]
                         && (rx_par != (parity_check_bus_i & (wide_q ? 8'hff : 8'h0f)));
      end
    end
  end

  // cpu strobe low exactly when in the issue state and its data driver is on
  strobe_drive_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!cpu_valid_n == (state_q == PSBS_ISSUE)) && (!cpu_valid_n == addr_data_bus_oe))
    else $error("cpu strobe and data drive disagree");
  // tag driven with strobe in out-of-order mode
  tag_with_valid_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!cpu_valid_n && unord_q) |-> request_tag_bus_oe)
    else $error("tag not driven with strobe");
  // issue needs the matching ready on the cycle before
  ready_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(cpu_valid_n) |-> $past(hold_wr_q ? !write_accept_n : !read_accept_n))
    else $error("request issued without ready");
  // narrow mode keeps upper half quiet
  narrow_half_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !wide_q |-> addr_data_bus_o[AD_W-1:AD_W32] == '0)
    else $error("upper half used in narrow mode");
  // narrow parity lanes
  narrow_par_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !wide_q |-> parity_check_bus_o[CK_W-1:CK_W32] == '0)
    else $error("upper parity used in narrow mode");
  // release leads to slave with the data driver off
  sequence rel_seq;
    !release_n ##1 (state_q == PSBS_SLAVE);
  endsequence
  release_slave_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(release_n) |-> rel_seq ##0 !addr_data_bus_oe)
    else $error("release did not reach slave");
  // pending shows a held, unissued request
  pending_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ($past(hold_q) && cpu_valid_n) |-> !cpu_pending_n)
    else $error("pending missing while request held");
  // no cpu drive in slave state
  slave_quiet_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_q == PSBS_SLAVE) |-> ##1 !addr_data_bus_oe)
    else $error("cpu drives bus while slave");
endmodule

// ---- bench/psbs_agent.sv ----
// external agent: drives pins toward the cpu, releases them when idle
module psbs_agent
  import psbs_pkg::*;
(
  input  wire logic             sys_clk, // system clock
  input  wire logic [AD_W-1:0]  ad_o,    // cpu data value
  input  wire logic             ad_oe,   // cpu drives data
  input  wire logic [CK_W-1:0]  ck_o,    // cpu parity value
  input  wire logic             ck_oe,   // cpu drives parity
  input  wire logic [CMD_W-1:0] cmd_o,   // cpu id value
  input  wire logic             cmd_oe,  // cpu drives id
  input  wire logic [TAG_W-1:0] tag_o,   // cpu tag value
  input  wire logic             tag_oe,  // cpu drives tag
  input  wire logic             send,    // agent word this cycle
  input  wire logic             bad,     // corrupt parity lane 0
  input  wire logic             rd_ok,   // agent takes reads
  input  wire logic             wr_ok,   // agent takes writes
  input  wire logic             want,    // agent wants the bus
  input  wire logic [AD_W-1:0]  s_ad,    // word to send
  input  wire logic [CMD_W-1:0] s_cmd,   // id to send
  input  wire logic [TAG_W-1:0] s_tag,   // tag to send
  output logic      [AD_W-1:0]  ad_i,    // resolved data pins
  output logic      [CK_W-1:0]  ck_i,    // resolved parity pins
  output logic      [CMD_W-1:0] cmd_i,   // resolved id pins
  output logic      [TAG_W-1:0] tag_i,   // resolved tag pins
  output logic                  valid_n, // agent strobe
  output logic                  rd_n,    // read ready
  output logic                  wr_n,    // write ready
  output logic                  breq_n   // bus request
);
  logic [AD_W-1:0] last_q = '0; // last pin level, inverted while floating
  logic [CK_W-1:0] par;    // even parity per byte of sent word
  // history so a floating bus never repeats a stale value
  always @(posedge sys_clk)
  begin
    last_q <= ad_i;
  end
  // byte parity, only in data cycles
  always_comb
  begin
    for (int i = 0; i < CK_W; i++) par[i] = ^s_ad[8*i +: 8];
    if (!s_cmd[CMD_DATA_BIT]) par = '0;
    par[0] = par[0] ^ bad;
  end
  // one driver per path: cpu enable wins, else agent, else float
  always_comb
  begin
    ad_i  = ad_oe ? ad_o : (send ? s_ad : ~last_q);
    ck_i  = ck_oe ? ck_o : (send ? par : ~last_q[CK_W-1:0]);
    cmd_i = cmd_oe ? cmd_o : (send ? s_cmd : ~last_q[CMD_W-1:0]);
    tag_i = tag_oe ? tag_o : (send ? s_tag : ~last_q[TAG_W-1:0]);
  end
  assign valid_n = ~send;
  assign rd_n    = ~rd_ok;
  assign wr_n    = ~wr_ok;
  assign breq_n  = ~want;
endmodule

// ---- bench/psbs_core_tb.sv ----
module psbs_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import psbs_pkg::*;
  logic             sys_clk = 1'b0, sys_rst = 1'b1;   // clock, reset
  logic             ws = WIDTH_64, un = UNORDERED_LVL; // straps
  logic             rv = 1'b0, rw = 1'b0, snd = 1'b0, bad = 1'b0; // stimulus
  logic             rok = 1'b1, wok = 1'b1, wb = 1'b0; // agent controls
  logic [AD_W-1:0]  rd = '0, sad = '0, ad_i, ad_o, rx_ad; // words
  logic [CK_W-1:0]  ck_i, ck_o;                       // parity
  logic [CMD_W-1:0] rc = '0, sc = '0, cmd_i, cmd_o, rx_cmd; // ids
  logic [TAG_W-1:0] rt = '0, st = '0, tag_i, tag_o, rx_tag; // tags
  logic             ad_oe, ck_oe, cmd_oe, tag_oe, av_n, cv_n, ra_n, wa_n;
  logic             br_n, rel_n, pend_n, rdy, rxv, perr; // handshakes
  int               failures = 0, checks_done = 0;    // counters
  logic [31:0]      rng = 32'h0000_0050;              // xorshift state
  psbs_core dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .width_select(ws),
    .unordered_return_sel_n(un), .addr_data_bus_i(ad_i), .addr_data_bus_o(ad_o),
    .addr_data_bus_oe(ad_oe), .parity_check_bus_i(ck_i), .parity_check_bus_o(ck_o),
    .parity_check_bus_oe(ck_oe), .command_id_bus_i(cmd_i), .command_id_bus_o(cmd_o),
    .command_id_bus_oe(cmd_oe), .request_tag_bus_i(tag_i), .request_tag_bus_o(tag_o),
    .request_tag_bus_oe(tag_oe), .agent_valid_n(av_n), .cpu_valid_n(cv_n),
    .read_accept_n(ra_n), .write_accept_n(wa_n), .agent_bus_request_n(br_n),
    .release_n(rel_n), .cpu_pending_n(pend_n), .req_valid(rv), .req_write(rw),
    .req_addr_data(rd), .req_cmd(rc), .req_tag(rt), .req_ready(rdy), .rx_valid(rxv),
    .rx_addr_data(rx_ad), .rx_cmd(rx_cmd), .rx_tag(rx_tag), .rx_parity_err(perr));
  psbs_agent ag_u (.sys_clk(sys_clk), .ad_o(ad_o), .ad_oe(ad_oe), .ck_o(ck_o),
    .ck_oe(ck_oe), .cmd_o(cmd_o), .cmd_oe(cmd_oe), .tag_o(tag_o), .tag_oe(tag_oe),
    .send(snd), .bad(bad), .rd_ok(rok), .wr_ok(wok), .want(wb), .s_ad(sad),
    .s_cmd(sc), .s_tag(st), .ad_i(ad_i), .ck_i(ck_i), .cmd_i(cmd_i), .tag_i(tag_i),
    .valid_n(av_n), .rd_n(ra_n), .wr_n(wa_n), .breq_n(br_n));
  // 40 MHz clock
  initial forever #12.5 sys_clk = ~sys_clk;
  // next random word
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // lanes in use for the strapped width
  function automatic logic [AD_W-1:0] msk(input logic [AD_W-1:0] d);
    return (ws === WIDTH_64) ? d : {32'h0000_0000, d[AD_W32-1:0]};
  endfunction
  // even byte parity, data cycles only, narrow lanes zero
  function automatic logic [CK_W-1:0] par(input logic [AD_W-1:0] d,
                                          input logic [CMD_W-1:0] c);
    logic [CK_W-1:0] p;
    for (int i = 0; i < CK_W; i++) p[i] = ^d[8*i +: 8];
    if (!c[CMD_DATA_BIT]) p = '0;
    if (ws !== WIDTH_64) p[CK_W-1:CK_W32] = '0;
    return p;
  endfunction
  task automatic chk(input logic [AD_W-1:0] s, input logic [AD_W-1:0] e);
    checks_done++;
    if (s !== e)
    begin
      failures++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // bounded wait: 0 slot free, 1 cpu strobe, 2 release pulse
  task automatic wait_for(input int w);
    int i;
    for (i = 0; i < 40; i++)
    begin
      @(negedge sys_clk);
      if ((w == 0 && rdy === 1'b1) || (w == 1 && cv_n === 1'b0)) break;
      if (w == 2 && rel_n === 1'b0) break;
    end
    if (i == 40)
    begin
      failures++;
      tally_and_finish();
    end
  endtask
  // straps only move while reset is held
  task automatic do_reset(input logic w, input logic u);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    ws <= w;
    un <= u;
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(cv_n & rel_n & pend_n, DEASSERT_N);
    chk(ad_oe | ck_oe | cmd_oe | tag_oe, 1'b0);
    @(posedge sys_clk) sys_rst <= 1'b0;
    wait_for(0);
  endtask
  // one request; blk 1 blocks its ready, 2 expects a bus hold to lift
  task automatic send(input logic w, input logic [AD_W-1:0] d,
                      input logic [CMD_W-1:0] c, input logic [TAG_W-1:0] t, input int blk);
    @(posedge sys_clk);
    {rv, rw, rd, rc, rt} <= {1'b1, w, d, c, t};
    if (blk == 1 && w) wok <= 1'b0;
    if (blk == 1 && !w) rok <= 1'b0;
    @(posedge sys_clk) rv <= 1'b0;
    if (blk != 0)
    begin
      repeat (4) @(negedge sys_clk);
      chk({pend_n, rdy}, 2'b00);
      chk(cv_n, 1'b1);
      @(posedge sys_clk);
      {rok, wok, wb} <= 3'b110;
    end
    wait_for(1);
    chk(ad_o, msk(d));
    chk(cmd_o, c);
    chk(tag_o, (un === UNORDERED_LVL) ? t : 3'h0);
    chk(tag_oe, un === UNORDERED_LVL);
    chk(ck_o, par(d, c));
    chk({ad_oe, ck_oe, cmd_oe, pend_n}, 4'b1111);
    @(negedge sys_clk);
    chk({cv_n, ad_oe}, 2'b10);
    wait_for(0);
  endtask
  // one agent word; b corrupts its parity
  task automatic rx_one(input logic b);
    @(posedge sys_clk);
    rng = xs(rng);
    {snd, bad, sad, sc, st} <= {1'b1, b, rng, ~rng, 1'b1, rng[7:0], rng[2:0]};
    @(posedge sys_clk) snd <= 1'b0;
    @(negedge sys_clk);
    chk({rxv, perr}, {1'b1, b});
    chk(rx_ad, msk(sad));
    chk(rx_cmd, sc);
    if (un === UNORDERED_LVL) chk(rx_tag, st);
    else chk(rx_tag, 3'h0);
  endtask
  initial
  begin
    logic [31:0] a;
    do_reset(WIDTH_64, UNORDERED_LVL);
    for (int m = 0; m < 2; m++)
    begin
      if (m == 1) do_reset(~WIDTH_64, ~UNORDERED_LVL);
      // random requests; first two stall on their own ready
      for (int k = 0; k < 6; k++)
      begin
        rng = xs(rng);
        a = rng;
        rng = xs(rng);
        send((k < 2) ? k[0] : a[0], {a, rng}, {rng[8] | k == 1, rng[7:0]}, a[3:1],
             (k < 2) ? 1 : 0);
      end
      // hand the bus over, take words, then a request held off
      @(posedge sys_clk) wb <= 1'b1;
      wait_for(2);
      @(negedge sys_clk);
      chk(rel_n, 1'b1);
      for (int k = 0; k < 3; k++) rx_one(k == 2);
      send(1'b0, {rng, a}, 9'h1_23, 3'h5, 2);
      $display("mode %0d finished", m);
    end
    tally_and_finish();
  end
endmodule
